// ==== logic/rtcpin_pkg.sv ====
// Constants, register layout and timing for the RTC pin supervisor.
// Assumes a 50 MHz core clock; all times are converted to core cycles.
package rtcpin_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ         = 50_000_000;
    localparam int T_DEBOUNCE_MS  = 250;
    localparam int T_RST_HOLD_MS  = 250;
    localparam int T_RECOVER_MS   = 125;
    localparam int T_OSF_MS       = 100;
    localparam int T_OSC_START_MS = 1000;
    localparam int SETTLE_CYC     = 4;
    localparam int CNT_W          = 27;

    function automatic int ms_to_cyc(input int ms);
        ms_to_cyc = ms * (CLK_HZ / 1000);
    endfunction

    localparam int DEBOUNCE_CYC  = ms_to_cyc(T_DEBOUNCE_MS);
    localparam int RST_HOLD_CYC  = ms_to_cyc(T_RST_HOLD_MS);
    localparam int RECOVER_CYC   = ms_to_cyc(T_RECOVER_MS);
    localparam int OSF_CYC       = ms_to_cyc(T_OSF_MS);
    localparam int OSC_START_CYC = ms_to_cyc(T_OSC_START_MS);

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;

    localparam int CTRL_CLK_EN    = 0;
    localparam int CTRL_BAT_CLK   = 1;
    localparam int CTRL_INT_MODE  = 2;
    localparam int CTRL_RATE_LO   = 3;
    localparam int CTRL_RATE_HI   = 4;
    localparam int CTRL_ALM1_EN   = 5;
    localparam int CTRL_ALM2_EN   = 6;
    localparam int CTRL_OSC_DIS   = 7;
    localparam logic [7:0] CTRL_RESET = 8'h07;

    localparam int STAT_OSC_HALT  = 0;
    localparam int STAT_RST_BUSY  = 1;
    localparam int STAT_ALM1      = 2;
    localparam int STAT_ALM2      = 3;
    localparam int STAT_OSC_RUN   = 4;

    // ------------------------------------------------------------------
    // Square wave taps on the oscillator divider
    // ------------------------------------------------------------------
    localparam int DIV_W     = 15;
    localparam int WAVE_TAP0 = 14;
    localparam int WAVE_TAP1 = 10;
    localparam int WAVE_TAP2 = 2;
    localparam int WAVE_TAP3 = 0;

    typedef enum logic [5:0] {
        RS_IDLE     = 6'b000001,
        RS_PFAIL    = 6'b000010,
        RS_RECOVER  = 6'b000100,
        RS_DEBOUNCE = 6'b001000,
        RS_WAITRISE = 6'b010000,
        RS_HOLD     = 6'b100000
    } rtcpin_rst_state_t;

endpackage

// ==== logic/rtcpin_link_if.sv ====
// Signals between the oscillator-domain divider and the core.
// Assumes tick_tog and wave_lvl are resynchronised by the receiver.
`timescale 1ns/1ps
interface rtcpin_link_if;
    logic       tick_tog;
    logic       wave_lvl;
    logic [1:0] rate_sel;

    modport link (output tick_tog, output wave_lvl, input rate_sel);
    modport core (input tick_tog, input wave_lvl, output rate_sel);
endinterface

// ==== logic/rtcpin_wave_gen.sv ====
// Oscillator-domain divider: activity toggle and square wave source.
// Assumes osc_clk may stop; rate_sel is quasi-static and resynchronised.
`timescale 1ns/1ps
module rtcpin_wave_gen
    import rtcpin_pkg::*;
(
    input  wire logic   osc_clk,
    input  wire logic   srst,
    rtcpin_link_if.link lnk
);
    // ------------------------------------------------------------------
    // Synchronisers into the oscillator domain
    // ------------------------------------------------------------------
    logic             rst_s1_q, rst_s2_q;
    logic [1:0]       rate_s1_q, rate_s2_q, rate_s3_q, rate_q, rate_d;
    logic [DIV_W-1:0] div_q, div_d;
    logic             tog_q, tog_d, wave_q, wave_d;

    function automatic logic pick_tap(input logic [DIV_W-1:0] v,
                                      input logic [1:0] sel);
        case (sel)
            2'h0:    pick_tap = v[WAVE_TAP0];
            2'h1:    pick_tap = v[WAVE_TAP1];
            2'h2:    pick_tap = v[WAVE_TAP2];
            default: pick_tap = v[WAVE_TAP3];
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------
    always_comb begin
        div_d  = div_q + 15'h0001;
        tog_d  = ~tog_q;
        // Accept a rate only once two samples agree
        rate_d = rate_q;
        if (rate_s2_q == rate_s3_q) begin
            rate_d = rate_s2_q;
        end
        wave_d = pick_tap(div_q, rate_q);
        if (rst_s2_q) begin
            div_d  = 15'h0000;
            tog_d  = 1'b0;
            wave_d = 1'b0;
        end
    end

    always_ff @(posedge osc_clk) begin
        rst_s1_q  <= srst;
        rst_s2_q  <= rst_s1_q;
        rate_s1_q <= lnk.rate_sel;
        rate_s2_q <= rate_s1_q;
        rate_s3_q <= rate_s2_q;
        rate_q    <= rate_d;
        div_q     <= div_d;
        tog_q     <= tog_d;
        wave_q    <= wave_d;
    end

    assign lnk.tick_tog = tog_q;
    assign lnk.wave_lvl = wave_q;
endmodule

// ==== logic/rtcpin_top.sv ====
// Reset line supervisor, shared interrupt/wave pin, reference clock gate
// and oscillator halt flag of a serial real-time clock.
// Assumes pins and the oscillator clock are asynchronous to ref_clk.
`timescale 1ns/1ps
module rtcpin_top
    import rtcpin_pkg::*;
#(
    parameter logic [CNT_W-1:0] DEBOUNCE_CYCLES  = CNT_W'(DEBOUNCE_CYC),
    parameter logic [CNT_W-1:0] RST_HOLD_CYCLES  = CNT_W'(RST_HOLD_CYC),
    parameter logic [CNT_W-1:0] RECOVER_CYCLES   = CNT_W'(RECOVER_CYC),
    parameter logic [CNT_W-1:0] OSF_CYCLES       = CNT_W'(OSF_CYC),
    parameter logic [CNT_W-1:0] OSC_START_CYCLES = CNT_W'(OSC_START_CYC)
)(
    input  wire logic       ref_clk,
    input  wire logic       srst,
    input  wire logic       osc_clk,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       supply_ok,
    input  wire logic       alarm1_match,
    input  wire logic       alarm2_match,
    input  wire logic       scl_in,
    input  wire logic       rst_pin_in,
    output logic            rst_pin_out,
    output logic            rst_pin_oe,
    output logic            irq_wave_out,
    output logic            irq_wave_oe,
    output logic            reference_clock_pin,
    output logic            osc_enable,
    output logic            scl_seen
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    rtcpin_link_if lnk ();

    logic              sup_s1_q;
    logic              sup_s2_q;
    logic              pin_s1_q;
    logic              pin_s2_q;
    logic              pin_s3_q;
    logic              tick_s1_q;
    logic              tick_s2_q;
    logic              tick_s3_q;
    logic              wave_s1_q;
    logic              wave_s2_q;
    logic              scl_s1_q;
    logic              scl_s2_q;
    logic [7:0]        ctrl_q;
    logic [7:0]        ctrl_d;
    logic [7:0]        rdata_q;
    logic [7:0]        rdata_d;
    logic              halt_q;
    logic              halt_d;
    logic              run_q;
    logic              run_d;
    logic              alm1_q;
    logic              alm1_d;
    logic              alm2_q;
    logic              alm2_d;
    logic [CNT_W-1:0]  halt_cnt_q;
    logic [CNT_W-1:0]  halt_cnt_d;
    logic [CNT_W-1:0]  cnt_q;
    logic [CNT_W-1:0]  cnt_d;
    rtcpin_rst_state_t st_q;
    rtcpin_rst_state_t st_d;
    logic              rst_oe_q;
    logic              rst_oe_d;
    logic              irq_oe_q;
    logic              irq_oe_d;
    logic              refpin_q;
    logic              refpin_d;
    logic              osc_en_q;
    logic              osc_en_d;
    logic              clr_halt;
    logic              clr_alm1;
    logic              clr_alm2;
    logic              pin_fall;
    logic              pin_rise;
    logic              tick_chg;
    logic              irq_active;
    logic              wave_bit;

    function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] v);
        dec = (v == '0) ? '0 : v - CNT_W'(1);
    endfunction

    rtcpin_wave_gen u_wave (
        .osc_clk (osc_clk),
        .srst    (srst),
        .lnk     (lnk)
    );

    assign lnk.rate_sel = {ctrl_q[CTRL_RATE_HI], ctrl_q[CTRL_RATE_LO]};

    // ------------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------------
    always_comb begin
        clr_halt = reg_wr && reg_addr == ADDR_STATUS
                   && reg_wdata[STAT_OSC_HALT];
        clr_alm1 = reg_wr && reg_addr == ADDR_STATUS
                   && reg_wdata[STAT_ALM1];
        clr_alm2 = reg_wr && reg_addr == ADDR_STATUS
                   && reg_wdata[STAT_ALM2];
        ctrl_d = ctrl_q;
        if (reg_wr && reg_addr == ADDR_CTRL) begin
            ctrl_d = reg_wdata;
        end
        rdata_d = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_CTRL:   rdata_d = ctrl_q;
                ADDR_STATUS: begin
                    rdata_d[STAT_OSC_HALT] = halt_q;
                    rdata_d[STAT_RST_BUSY] = (st_q != RS_IDLE);
                    rdata_d[STAT_ALM1]     = alm1_q;
                    rdata_d[STAT_ALM2]     = alm2_q;
                    rdata_d[STAT_OSC_RUN]  = run_q;
                end
                default:     rdata_d = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Oscillator activity and halt flag
    // ------------------------------------------------------------------
    always_comb begin
        tick_chg   = tick_s2_q ^ tick_s3_q;
        halt_cnt_d = halt_cnt_q;
        run_d      = run_q;
        halt_d     = halt_q & ~clr_halt;
        if (tick_chg) begin
            halt_cnt_d = '0;
            run_d      = 1'b1;
        end else if (halt_cnt_q < OSF_CYCLES) begin
            halt_cnt_d = halt_cnt_q + CNT_W'(1);
        end else begin
            run_d  = 1'b0;
            halt_d = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Alarm flags and shared pin
    // ------------------------------------------------------------------
    always_comb begin
        alm1_d     = (alm1_q & ~clr_alm1) | alarm1_match;
        alm2_d     = (alm2_q & ~clr_alm2) | alarm2_match;
        irq_active = (alm1_q & ctrl_q[CTRL_ALM1_EN])
                   | (alm2_q & ctrl_q[CTRL_ALM2_EN]);
        wave_bit   = wave_s2_q;
        if (ctrl_q[CTRL_INT_MODE]) begin
            irq_oe_d = irq_active;
        end else begin
            irq_oe_d = ~wave_bit;
        end
        refpin_d = tick_s2_q & ctrl_q[CTRL_CLK_EN]
                   & ctrl_q[CTRL_BAT_CLK];
        osc_en_d = ~ctrl_q[CTRL_OSC_DIS];
    end

    // ------------------------------------------------------------------
    // Reset line sequencer
    // ------------------------------------------------------------------
    always_comb begin
        pin_fall = pin_s3_q & ~pin_s2_q;
        pin_rise = ~pin_s3_q & pin_s2_q;
        st_d     = st_q;
        cnt_d    = dec(cnt_q);
        case (st_q)
            RS_IDLE: begin
                if (pin_fall) begin
                    st_d  = RS_DEBOUNCE;
                    cnt_d = DEBOUNCE_CYCLES;
                end
            end
            RS_PFAIL: begin
                if (sup_s2_q) begin
                    if (ctrl_q[CTRL_OSC_DIS] || !run_q) begin
                        st_d = RS_IDLE;
                    end else begin
                        st_d  = RS_RECOVER;
                        cnt_d = RECOVER_CYCLES;
                    end
                end
            end
            RS_RECOVER: begin
                if (cnt_q == '0) begin
                    st_d = RS_IDLE;
                end
            end
            RS_DEBOUNCE: begin
                if (cnt_q == '0) begin
                    st_d  = RS_WAITRISE;
                    cnt_d = CNT_W'(SETTLE_CYC);
                end
            end
            RS_WAITRISE: begin
                if (cnt_q == '0) begin
                    if (pin_rise) begin
                        st_d  = RS_HOLD;
                        cnt_d = ctrl_q[CTRL_OSC_DIS]
                              ? RST_HOLD_CYCLES + OSC_START_CYCLES
                              : RST_HOLD_CYCLES;
                    end else if (pin_s2_q) begin
                        st_d = RS_IDLE;
                    end
                end
            end
            RS_HOLD: begin
                if (cnt_q == '0) begin
                    st_d = RS_IDLE;
                end
            end
            default: st_d = RS_IDLE;
        endcase
        if (!sup_s2_q) begin
            st_d  = RS_PFAIL;
            cnt_d = '0;
        end
        rst_oe_d = (st_d == RS_PFAIL) || (st_d == RS_RECOVER)
                || (st_d == RS_DEBOUNCE) || (st_d == RS_HOLD);
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        sup_s1_q  <= supply_ok;
        sup_s2_q  <= sup_s1_q;
        pin_s1_q  <= rst_pin_in;
        pin_s2_q  <= pin_s1_q;
        pin_s3_q  <= pin_s2_q;
        tick_s1_q <= lnk.tick_tog;
        tick_s2_q <= tick_s1_q;
        tick_s3_q <= tick_s2_q;
        wave_s1_q <= lnk.wave_lvl;
        wave_s2_q <= wave_s1_q;
        scl_s1_q  <= scl_in;
        scl_s2_q  <= scl_s1_q;
        if (srst) begin
            ctrl_q     <= CTRL_RESET;
            rdata_q    <= 8'h00;
            halt_q     <= 1'b0;
            run_q      <= 1'b0;
            halt_cnt_q <= '0;
            alm1_q     <= 1'b0;
            alm2_q     <= 1'b0;
            st_q       <= RS_PFAIL;
            cnt_q      <= '0;
            rst_oe_q   <= 1'b1;
            irq_oe_q   <= 1'b0;
            refpin_q   <= 1'b0;
            osc_en_q   <= 1'b1;
        end else begin
            ctrl_q     <= ctrl_d;
            rdata_q    <= rdata_d;
            halt_q     <= halt_d;
            run_q      <= run_d;
            halt_cnt_q <= halt_cnt_d;
            alm1_q     <= alm1_d;
            alm2_q     <= alm2_d;
            st_q       <= st_d;
            cnt_q      <= cnt_d;
            rst_oe_q   <= rst_oe_d;
            irq_oe_q   <= irq_oe_d;
            refpin_q   <= refpin_d;
            osc_en_q   <= osc_en_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata           = rdata_q;
    assign rst_pin_out         = 1'b0;
    assign rst_pin_oe          = rst_oe_q;
    assign irq_wave_out        = 1'b0;
    assign irq_wave_oe         = irq_oe_q;
    assign reference_clock_pin = refpin_q;
    assign osc_enable          = osc_en_q;
    assign scl_seen            = scl_s2_q;
endmodule

// ==== bench/rtcpin_top_chk.sv ====
// Checker for the RTC pin supervisor.
// Assumes it is bound to rtcpin_top and sees only its ports.
`timescale 1ns/1ps
module rtcpin_top_chk
    import rtcpin_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       srst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       supply_ok,
    input wire logic       alarm1_match,
    input wire logic       scl_in,
    input wire logic       rst_pin_oe,
    input wire logic       irq_wave_oe,
    input wire logic       reference_clock_pin,
    input wire logic       osc_enable,
    input wire logic       scl_seen
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    // ----------------
    // Control shadow
    // ----------------
    always_comb begin
        ctrl_d = ctrl_q;
        if (reg_wr && reg_addr == ADDR_CTRL) begin
            ctrl_d = reg_wdata;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl_q <= CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end
    ref_gate_a: assert property (reference_clock_pin |->
        $past(ctrl_q[0] && ctrl_q[1])) else $error("ref pin not gated");
    osc_ctrl_a: assert property (
        osc_enable == !$past(ctrl_q[7])) else $error("osc enable wrong");
    irq_quiet_a: assert property (
        (ctrl_q[2] && !ctrl_q[5] && !ctrl_q[6])[*4] |-> !irq_wave_oe)
        else $error("irq without enable");
    alarm_irq_a: assert property (
        alarm1_match && ctrl_q[2] && ctrl_q[5] |-> ##[1:4] irq_wave_oe)
        else $error("alarm irq missing");
    pfail_hold_a: assert property (
        (!supply_ok)[*6] |-> rst_pin_oe) else $error("pfail not driven");
    pfail_bypass_a: assert property (
        $rose(supply_ok) && ctrl_q[7] |-> ##[1:8] !rst_pin_oe)
        else $error("bypass release late");
    reset_pulse_a: assert property (
        $rose(rst_pin_oe) |-> rst_pin_oe[*8]) else $error("reset glitch");
    scl_follow_a: assert property (
        $rose(scl_in) |-> ##[1:4] scl_seen) else $error("scl not seen");
    rdata_idle_a: assert property (
        !reg_rd |=> reg_rdata == 8'h00) else $error("rdata not idle");
    cover property ($rose(irq_wave_oe));
    cover property ($fell(rst_pin_oe));
    cover property ($rose(reference_clock_pin));
endmodule

bind rtcpin_top rtcpin_top_chk u_chk (.ref_clk(ref_clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .supply_ok(supply_ok),
    .alarm1_match(alarm1_match), .scl_in(scl_in),
    .rst_pin_oe(rst_pin_oe), .irq_wave_oe(irq_wave_oe),
    .reference_clock_pin(reference_clock_pin),
    .osc_enable(osc_enable), .scl_seen(scl_seen));

// ==== bench/rtcpin_bus_ctl.sv ====
// Bus controller model: makes the serial clock of the two-wire bus.
// Assumes the device only samples the clock; idle level is pulled up.
`timescale 1ns/1ps
module rtcpin_bus_ctl #(
    parameter int HALF_NS = 1250
)(
    input  wire logic run,
    output logic      scl
);
    initial begin
        scl = 1'b1;
        forever begin
            #(HALF_NS);
            scl = run ? ~scl : 1'b1;
        end
    end
endmodule

// ==== bench/rtcpin_top_test.sv ====
// Self-checking bench for the RTC pin supervisor.
// Assumes shortened counts; reset pin has a pull-up, button pulls low.
`timescale 1ns/1ps
module rtcpin_top_test;
    import rtcpin_pkg::*;
    localparam int N_DEB = 40, N_HOLD = 60, N_REC = 50;
    localparam int N_OSF = 20, N_OSC = 80;
    logic ref_clk = 0, srst = 1, osc_clk = 0, osc_run = 1;
    logic reg_wr = 0, reg_rd = 0, supply_ok = 1, button = 0;
    logic alarm1_match = 0, alarm2_match = 0, bus_run = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
    logic scl_in, rst_pin_out, rst_pin_oe, irq_wave_out, irq_wave_oe;
    logic reference_clock_pin, osc_enable, scl_seen;
    wire  rst_pin_in = !(rst_pin_oe === 1'b1 || button);
    int   n_errors = 0, n_tests = 0;

    initial forever #10 ref_clk = ~ref_clk;
    initial begin
        #7;
        forever begin
            #32;
            if (osc_run && osc_enable === 1'b1) osc_clk = ~osc_clk;
        end
    end

    rtcpin_top #(.DEBOUNCE_CYCLES(CNT_W'(N_DEB)),
        .RST_HOLD_CYCLES(CNT_W'(N_HOLD)), .RECOVER_CYCLES(CNT_W'(N_REC)),
        .OSF_CYCLES(CNT_W'(N_OSF)), .OSC_START_CYCLES(CNT_W'(N_OSC))
    ) i_dut (.ref_clk(ref_clk), .srst(srst), .osc_clk(osc_clk),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .supply_ok(supply_ok),
        .alarm1_match(alarm1_match), .alarm2_match(alarm2_match),
        .scl_in(scl_in), .rst_pin_in(rst_pin_in),
        .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
        .irq_wave_out(irq_wave_out), .irq_wave_oe(irq_wave_oe),
        .reference_clock_pin(reference_clock_pin),
        .osc_enable(osc_enable), .scl_seen(scl_seen));
    rtcpin_bus_ctl i_bus (.run(bus_run), .scl(scl_in));

    // ----------------
    // Helpers
    // ----------------
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("CHECK FAILED %s exp %0h got %0h", nm, e, g);
            n_errors++;
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge ref_clk);
        reg_wr <= 0;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1;
        @(posedge ref_clk);
        reg_rd <= 0;
        #1 d = reg_rdata;
    endtask
    task wait_oe(input logic v, output int n);
        n = 0;
        while (rst_pin_oe !== v && n < 3000) begin
            @(posedge ref_clk);
            #1 n++;
        end
    endtask
    task print_verdict;
        $display("errors %0d checks %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ----------------
    // Scenarios
    // ----------------
    task t_reset;
        logic [7:0] d;
        rd(ADDR_CTRL, d);
        chk("ctrl reset", CTRL_RESET, d);
        wr(8'h10, 8'hFF);
        rd(8'h10, d);
        chk("unmapped", 8'h00, d);
        rd(ADDR_CTRL, d);
        chk("ctrl kept", CTRL_RESET, d);
        chk("irq idle", 0, irq_wave_oe);
        chk("rst free", 0, rst_pin_oe);
        chk("rst out", 0, rst_pin_out);
        chk("irq out", 0, irq_wave_out);
    endtask
    task t_refclk;
        int hi;
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_CTRL, 8'h04 | 8'(m));
            cyc(8);
            hi = 0;
            repeat (40) begin
                @(posedge ref_clk);
                #1 if (reference_clock_pin === 1'b1) hi++;
            end
            chk("ref pin", m == 3, hi > 0);
        end
    endtask
    task t_wave;
        int tg;
        int len;
        logic p;
        for (int r = 0; r < 4; r++) begin
            len = (r == 1) ? 3500 : 200;
            wr(ADDR_CTRL, 8'h03 | 8'(r << 3));
            cyc(30);
            tg = 0;
            #1 p = irq_wave_oe;
            repeat (len) begin
                @(posedge ref_clk);
                #1 if (irq_wave_oe !== p) tg++;
                p = irq_wave_oe;
            end
            chk("wave", r > 0, tg > (r > 1 ? 4 : 0));
        end
    endtask
    task t_alarm;
        wr(ADDR_CTRL, 8'h24);
        wr(ADDR_STATUS, 8'h0C);
        cyc(4);
        #1 chk("irq quiet", 0, irq_wave_oe);
        @(posedge ref_clk) alarm2_match <= 1;
        @(posedge ref_clk) alarm2_match <= 0;
        cyc(4);
        #1 chk("alarm2 masked", 0, irq_wave_oe);
        @(posedge ref_clk) alarm1_match <= 1;
        @(posedge ref_clk) alarm1_match <= 0;
        cyc(4);
        #1 chk("alarm1 irq", 1, irq_wave_oe);
        wr(ADDR_STATUS, 8'h0C);
        cyc(4);
        #1 chk("irq cleared", 0, irq_wave_oe);
    endtask
    task t_pfail(input logic [7:0] c, input int lo, input int hi);
        int n;
        wr(ADDR_CTRL, c);
        cyc(40);
        #1 chk("osc enable", !c[7], osc_enable);
        @(posedge ref_clk) supply_ok <= 0;
        cyc(10);
        #1 chk("pfail", 1, rst_pin_oe);
        @(posedge ref_clk) supply_ok <= 1;
        #1 wait_oe(0, n);
        chk("recovery", 1, n >= lo && n <= hi);
    endtask
    task t_button(input logic [7:0] c, input int hold);
        int n;
        wr(ADDR_CTRL, c);
        cyc(20);
        @(posedge ref_clk) button <= 1;
        #1 wait_oe(1, n);
        chk("press", 1, n <= 6);
        wait_oe(0, n);
        chk("debounce", 1, n >= N_DEB - 3 && n <= N_DEB + 3);
        cyc(20);
        #1 chk("await rise", 0, rst_pin_oe);
        @(posedge ref_clk) button <= 0;
        #1 wait_oe(1, n);
        chk("rise seen", 1, n <= 8);
        wait_oe(0, n);
        chk("hold", 1, n >= hold - 3 && n <= hold + 3);
    endtask
    task t_halt;
        logic [7:0] d;
        wr(ADDR_CTRL, 8'h04);
        cyc(20);
        wr(ADDR_STATUS, 8'h01);
        rd(ADDR_STATUS, d);
        chk("halt clear", 0, d[0]);
        @(posedge ref_clk) osc_run <= 0;
        cyc(N_OSF - 6);
        rd(ADDR_STATUS, d);
        chk("halt early", 0, d[0]);
        cyc(16);
        rd(ADDR_STATUS, d);
        chk("halt set", 1, d[0]);
        @(posedge ref_clk) osc_run <= 1;
    endtask

    initial begin
        cyc(16);
        srst <= 0;
        bus_run <= 1;
        cyc(80);
        t_reset;
        t_refclk;
        t_wave;
        t_alarm;
        t_pfail(8'h04, N_REC, N_REC + 8);
        t_pfail(8'h84, 0, 8);
        t_button(8'h04, N_HOLD);
        t_button(8'h84, N_HOLD + N_OSC);
        t_halt;
        print_verdict;
    end
    initial begin
        #200_000;
        n_errors++;
        print_verdict;
    end
endmodule
